/* bench/sarc_front_model.sv */
`timescale 1ns/100ps
module sarc_front_model import sarc_pkg::*; #(
    parameter int DELAY = 20
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // recal requests in, results out
    input  wire logic [NCHAN-1:0] recal_q,
    output sarc_cal_res_s         cal_res
);
    logic       busy_q;
    logic [7:0] cnt_q;

    // ------------------------------------------------------------
    // one channel at a time, lowest first; higher channels are slower
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cal_res.done  <= 1'b0;
        cal_res.value <= ~cal_res.value; // no stale value between results
        if (rst) begin
            busy_q        <= 1'b0;
            cal_res.chan  <= 3'h0;
            cal_res.value <= 16'h0000;
        end else if (busy_q) begin
            if (cnt_q == 8'h00) begin
                cal_res.done  <= 1'b1;
                cal_res.value <= 16'ha500 | 16'(cal_res.chan);
                busy_q        <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 8'h01;
            end
        end else if (!cal_res.done) begin
            // skip the cycle after done: the bit is still seen set then
            for (int i = NCHAN - 1; i >= 0; i--) begin
                if (recal_q[i]) begin
                    busy_q       <= 1'b1;
                    cal_res.chan <= 3'(i);
                    cnt_q        <= 8'(DELAY + 5 * i);
                end
            end
        end
    end
endmodule : sarc_front_model

/* bench/testbench.sv */
`timescale 1ns/100ps
module testbench import sarc_pkg::*; ();
    localparam int MSC   = 12;
    localparam int LIMIT = 95000;
    logic                     clk, rst, slider_touch, sensor_step, extra_irq_q;
    logic                     grouped_as_buttons_select;
    sarc_reg_req_s            reg_req;
    sarc_cal_res_s            cal_res;
    logic [7:0]               reg_rdata_q, slider_base_repeat_interval, repeat_ms_q;
    logic [NCHAN-1:0]         recal_q;
    logic [NCHAN-1:0][15:0]   base_q;
    int                       mismatches, total_checks, cycles, irqs;

    sarc_top #(.MS_CYC(MSC)) sarc_top_i (.clk(clk), .rst(rst), .reg_req(reg_req),
        .reg_rdata_q(reg_rdata_q), .slider_touch(slider_touch), .sensor_step(sensor_step),
        .grouped_as_buttons_select(grouped_as_buttons_select),
        .slider_base_repeat_interval(slider_base_repeat_interval),
        .extra_irq_q(extra_irq_q), .repeat_ms_q(repeat_ms_q), .cal_res(cal_res),
        .recal_q(recal_q), .base_q(base_q));
    sarc_front_model #(.DELAY(20)) sarc_front_model_i (.clk(clk), .rst(rst),
        .recal_q(recal_q), .cal_res(cal_res));

    // ------------------------------------------------------------
    // clock, extra interrupt counter and hang guard
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (extra_irq_q === 1'b1) irqs++;
        if (cycles == LIMIT) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (mismatches == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk16

    // ------------------------------------------------------------
    // register port: one-cycle request, read data the cycle after
    // ------------------------------------------------------------
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); #1;
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk); #1;
        reg_req = '0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk); #1;
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk); #1;
        reg_req = '0;
        chk8(what, exp, reg_rdata_q);
    endtask : reg_rd

    // one slide of ms milliseconds, then count extras for 160 ms
    task automatic slide(input logic [7:0] cfg, input int ms, input logic [7:0] exp);
        reg_wr(VEL_CFG_ADDR, cfg);
        slider_touch = 1'b1;
        repeat (ms * MSC) @(posedge clk);
        #1 slider_touch = 1'b0;
        irqs = 0;
        repeat (160 * MSC) @(posedge clk);
        #1;
        chk8("extra irq count", exp, 8'(irqs));
    endtask : slide

    // evenly spaced steps: every 100 ms window sees exactly k of them
    task automatic speed(input logic [1:0] sc, input int k);
        logic [7:0] exp;
        exp = (k >= 5) ? RPT_35_MS :
              (k == 4) ? ((sc == 2'b11) ? RPT_70_MS : RPT_35_MS) :
              (k == 3) ? ((sc == 2'b11) ? RPT_105_MS : (sc == 2'b10) ? RPT_70_MS : RPT_35_MS) :
              (k == 2) ? ((sc == 2'b11) ? RPT_140_MS : (sc == 2'b10) ? RPT_105_MS :
                          (sc == 2'b01) ? RPT_70_MS : RPT_35_MS) : slider_base_repeat_interval;
        reg_wr(VEL_CFG_ADDR, {6'b110001, sc});
        repeat (2 * k) begin
            sensor_step = 1'b1;
            @(posedge clk); #1;
            sensor_step = 1'b0;
            repeat (100 * MSC / k - 1) @(posedge clk);
            #1;
        end
        chk8("repeat interval", exp, repeat_ms_q);
    endtask : speed

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        reg_req = '0;
        slider_touch = 1'b0;
        sensor_step = 1'b0;
        grouped_as_buttons_select = 1'b0;
        slider_base_repeat_interval = 8'h64;
        mismatches = 0;
        total_checks = 0;
        cycles = 0;
        irqs = 0;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        chk8("repeat after reset", RPT_35_MS, repeat_ms_q);
        reg_rd(VEL_CFG_ADDR, VEL_CFG_RST, "velocity cfg reset");
        reg_rd(RECAL_ADDR, RECAL_RST, "recal reset");
        reg_wr(8'h40, 8'hff);
        reg_rd(8'h40, 8'h00, "unmapped read");
        reg_rd(VEL_CFG_ADDR, VEL_CFG_RST, "cfg after stray write");
        reg_wr(RECAL_ADDR, 8'h83);
        chk8("recal bits", 8'h83, recal_q);
        reg_wr(RECAL_ADDR, 8'h00);
        reg_rd(RECAL_ADDR, 8'h83, "recal after zero write");
        for (int i = 0; i < 400 && recal_q !== 8'h00; i++) @(posedge clk);
        reg_rd(RECAL_ADDR, 8'h00, "recal self clear");
        chk16("base chan 1", 16'ha500, base_q[0]);
        chk16("base chan 2", 16'ha501, base_q[1]);
        chk16("base group", 16'ha507, base_q[7]);
        slide(8'hc5, 100, 8'h04);
        slide(8'hc5, 350, 8'h02);
        slide(8'hc5, 500, 8'h01);
        slide(8'hc5, 600, 8'h00);
        slide(8'hf5, 350, 8'h03);
        slide(8'hb5, 500, 8'h00);
        slide(8'hc0, 200, 8'h02);
        slide(8'hcd, 400, 8'h04);
        slide(8'h45, 100, 8'h00);
        grouped_as_buttons_select = 1'b1;
        slide(8'hc5, 100, 8'h00);
        grouped_as_buttons_select = 1'b0;
        for (int s = 0; s < 4; s++) begin
            speed(2'(s), 2);
            speed(2'(s), 3);
        end
        speed(2'b11, 4);
        speed(2'b00, 4);
        speed(2'b11, 5);
        speed(2'b01, 1);
        print_verdict();
    end
endmodule : testbench

/* include/sarc_pkg.sv */
package sarc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] VEL_CFG_ADDR = 8'h3e;
    localparam logic [7:0] RECAL_ADDR   = 8'h3f;
    localparam logic [7:0] VEL_CFG_RST  = 8'hc5;
    localparam logic [7:0] RECAL_RST    = 8'h00;
    localparam int         ACC_EN_BIT   = 7;
    localparam int         MAX_LO       = 4;
    localparam int         WIN_LO       = 2;
    localparam int         SCL_LO       = 0;
    localparam int         NCHAN        = 8;

    // ------------------------------------------------------------
    // timing, all in ms unless named otherwise
    // ------------------------------------------------------------
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         MS_NS         = 1000000;
    localparam int         MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam logic [9:0] WIN0_MS       = 10'h15e;
    localparam logic [9:0] WIN1_MS       = 10'h230;
    localparam logic [9:0] WIN2_MS       = 10'h302;
    localparam logic [9:0] WIN3_MS       = 10'h3d4;
    localparam logic [6:0] SPEED_WIN_MS  = 7'h64;
    localparam logic [5:0] EXTRA_GAP_MS  = 6'h23;
    localparam logic [7:0] RPT_35_MS     = 8'h23;
    localparam logic [7:0] RPT_70_MS     = 8'h46;
    localparam logic [7:0] RPT_105_MS    = 8'h69;
    localparam logic [7:0] RPT_140_MS    = 8'h8c;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sarc_reg_req_s;

    typedef struct packed {
        logic        done;
        logic [2:0]  chan;
        logic [15:0] value;
    } sarc_cal_res_s;
endpackage : sarc_pkg

/* verilog/sarc_top.sv */
`timescale 1ns/100ps
module sarc_top import sarc_pkg::*; #(
    parameter int MS_CYC = MS_CYCLES
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // register port behind the serial bus
    input  wire sarc_reg_req_s      reg_req,
    output logic [7:0]              reg_rdata_q,
    // slider front end
    input  wire logic               slider_touch,
    input  wire logic               sensor_step,
    input  wire logic               grouped_as_buttons_select,
    input  wire logic [7:0]         slider_base_repeat_interval,
    output logic                    extra_irq_q,
    output logic [7:0]              repeat_ms_q,
    // calibration front end
    input  wire sarc_cal_res_s      cal_res,
    output logic [NCHAN-1:0]        recal_q,
    output logic [NCHAN-1:0][15:0]  base_q
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [9:0] win_ms(input logic [1:0] sel);
        unique case (sel)
            2'b00:   win_ms = WIN0_MS;
            2'b01:   win_ms = WIN1_MS;
            2'b10:   win_ms = WIN2_MS;
            default: win_ms = WIN3_MS;
        endcase
    endfunction : win_ms

    // comparisons widened so 3/4 of the window never overflows
    function automatic logic [2:0] extra_n(input logic [2:0] mx,
                                           input logic [9:0] t,
                                           input logic [9:0] w);
        logic [11:0] t2;
        logic [11:0] t4;
        logic [11:0] w3;
        t2 = {1'b0, t, 1'b0};
        t4 = {t, 2'b00};
        w3 = {2'b00, w} + {1'b0, w, 1'b0};
        if (t2 < {2'b00, w})
            extra_n = mx;
        else if (t4 < w3)
            extra_n = mx >> 1;
        else if (t <= w)
            extra_n = {2'b00, mx[2]};
        else
            extra_n = 3'h0;
    endfunction : extra_n

    function automatic logic [7:0] rpt_ms(input logic [2:0] n,
                                          input logic [1:0] sc,
                                          input logic [7:0] base);
        logic [1:0] k;
        k = 2'h0;
        if (n >= 3'h5)
            rpt_ms = RPT_35_MS;
        else if (n <= 3'h1)
            rpt_ms = base;
        else begin
            // slower slide and larger scale push the interval up
            if (n == 3'h4)
                k = (sc == 2'b11) ? 2'h1 : 2'h0;
            else if (n == 3'h3)
                k = (sc == 2'b00) ? 2'h0 : sc - 2'h1;
            else
                k = sc;
            unique case (k)
                2'h0:    rpt_ms = RPT_35_MS;
                2'h1:    rpt_ms = RPT_70_MS;
                2'h2:    rpt_ms = RPT_105_MS;
                default: rpt_ms = RPT_140_MS;
            endcase
        end
    endfunction : rpt_ms

    // ------------------------------------------------------------
    // registers and decode
    // ------------------------------------------------------------
    logic [7:0]        cfg_q;
    logic [7:0]        cfg_d;
    logic [NCHAN-1:0]  recal_d;
    wire logic         wr_cfg    = reg_req.wr && reg_req.addr == VEL_CFG_ADDR;
    wire logic         wr_recal  = reg_req.wr && reg_req.addr == RECAL_ADDR;
    wire logic         acc_en    = cfg_q[ACC_EN_BIT];
    wire logic [2:0]   max_int   = cfg_q[MAX_LO +: 3];
    wire logic [1:0]   win_sel   = cfg_q[WIN_LO +: 2];
    wire logic [1:0]   scale     = cfg_q[SCL_LO +: 2];
    wire logic         slider_md = !grouped_as_buttons_select;
    wire logic [NCHAN-1:0] set_v = wr_recal ? reg_req.wdata : '0;
    wire logic [NCHAN-1:0] clr_v = cal_res.done ? NCHAN'(1) << cal_res.chan : '0;
    wire logic [7:0]   rd_mux    = reg_req.addr == VEL_CFG_ADDR ? cfg_q :
                                   reg_req.addr == RECAL_ADDR ? recal_q : 8'h00;

    // a new request beats the completion of the previous one
    assign cfg_d   = wr_cfg ? reg_req.wdata : cfg_q;
    assign recal_d = (recal_q & ~clr_v) | set_v;

    // register file
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q       <= VEL_CFG_RST;
            recal_q     <= RECAL_RST;
            reg_rdata_q <= 8'h00;
        end else begin
            cfg_q       <= cfg_d;
            recal_q     <= recal_d;
            reg_rdata_q <= reg_req.rd ? rd_mux : reg_rdata_q;
        end
    end

    // base counts refreshed only by a finished recalibration
    always_ff @(posedge clk) begin
        if (rst)
            base_q <= '0;
        else if (cal_res.done)
            base_q[cal_res.chan] <= cal_res.value;
    end

    // ------------------------------------------------------------
    // millisecond tick
    // ------------------------------------------------------------
    logic [16:0] div_q;
    wire logic   ms_tick = div_q == 17'(MS_CYC - 1);

    always_ff @(posedge clk) begin
        if (rst || ms_tick)
            div_q <= 17'h0;
        else
            div_q <= div_q + 17'h1;
    end

    // ------------------------------------------------------------
    // slide timing and extra interrupts
    // ------------------------------------------------------------
    logic       touch_q;
    logic [9:0] t_ms_q;
    logic [2:0] left_q;
    logic [5:0] gap_q;
    wire logic  slide_end = touch_q && !slider_touch && slider_md;
    wire logic  t_sat     = &t_ms_q;
    wire logic  gap_done  = ms_tick && gap_q == EXTRA_GAP_MS - 6'h1;
    wire logic  fire      = acc_en && left_q != 3'h0 && gap_done;
    wire logic [2:0] n_new = extra_n(max_int, t_ms_q, win_ms(win_sel));

    // slide time saturates at 1023 ms, just beyond the longest window (980 ms)
    always_ff @(posedge clk) begin
        if (rst) begin
            touch_q <= 1'b0;
            t_ms_q  <= 10'h0;
        end else begin
            touch_q <= slider_touch;
            if (slider_touch && !touch_q)
                t_ms_q <= 10'h0;
            else if (slider_touch && ms_tick && !t_sat)
                t_ms_q <= t_ms_q + 10'h1;
        end
    end

    // extras are spaced one gap apart after release
    always_ff @(posedge clk) begin
        if (rst || !acc_en || !slider_md) begin
            left_q      <= 3'h0;
            gap_q       <= 6'h0;
            extra_irq_q <= 1'b0;
        end else begin
            extra_irq_q <= fire;
            if (slide_end) begin
                left_q <= n_new;
                gap_q  <= 6'h0;
            end else if (left_q != 3'h0 && ms_tick) begin
                gap_q  <= gap_done ? 6'h0 : gap_q + 6'h1;
                left_q <= fire ? left_q - 3'h1 : left_q;
            end
        end
    end

    // ------------------------------------------------------------
    // speed window and repeat interval
    // ------------------------------------------------------------
    logic [6:0] sw_q;
    logic [2:0] steps_q;
    wire logic  sw_end = ms_tick && sw_q == SPEED_WIN_MS - 7'h1;
    wire logic [2:0] steps_n = (steps_q == 3'h5) ? steps_q : steps_q + 3'h1;

    // step count saturates at five; more never changes the answer
    always_ff @(posedge clk) begin
        if (rst) begin
            sw_q        <= 7'h0;
            steps_q     <= 3'h0;
            repeat_ms_q <= RPT_35_MS;
        end else begin
            if (ms_tick)
                sw_q <= sw_end ? 7'h0 : sw_q + 7'h1;
            if (sw_end) begin
                // a step on the closing edge opens the next window, never lost
                steps_q <= {2'b00, sensor_step && slider_md};
                repeat_ms_q <= slider_md ?
                    rpt_ms(steps_q, scale, slider_base_repeat_interval) :
                    slider_base_repeat_interval;
            end else if (sensor_step && slider_md) begin
                steps_q <= steps_n;
            end
        end
    end

    // ------------------------------------------------------------
    // check helpers
    // ------------------------------------------------------------
    logic [3:0] sent_q;
    logic [2:0] lim_q;

    // extras charged to the latest release only; a late one from the
    // previous slide that fires on the release edge is not counted
    always_ff @(posedge clk) begin
        if (rst) begin
            sent_q <= 4'h0;
            lim_q  <= 3'h0;
        end else if (slide_end) begin
            sent_q <= 4'h0;
            lim_q  <= max_int;
        end else if (fire && sent_q != 4'hf) begin
            sent_q <= sent_q + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_accel_gate: assert property (@(posedge clk) disable iff (rst)
        !acc_en |=> !extra_irq_q) else $error("extra irq while disabled");
    chk_extra_cap: assert property (@(posedge clk) disable iff (rst)
        slide_end |=> left_q <= $past(max_int))
        else $error("extra count above limit");
    chk_cfg_reset: assert property (@(posedge clk)
        $past(rst) |-> cfg_q == 8'hc5) else $error("bad config reset");
    chk_fast_slide: assert property (@(posedge clk) disable iff (rst)
        slide_end && acc_en && !wr_cfg && 12'({t_ms_q, 1'b0}) < 12'(win_ms(win_sel))
        |=> left_q == $past(max_int)) else $error("fast slide not full");
    chk_slow_slide: assert property (@(posedge clk) disable iff (rst)
        slide_end && t_ms_q > win_ms(win_sel) |=> left_q == 3'h0)
        else $error("slow slide got extras");
    chk_speed_top: assert property (@(posedge clk) disable iff (rst)
        sw_end && slider_md && steps_q == 3'h5 |=> repeat_ms_q == 8'h23)
        else $error("fast repeat not 35");
    chk_one_sensor: assert property (@(posedge clk) disable iff (rst)
        sw_end && steps_q <= 3'h1 |=> repeat_ms_q == $past(slider_base_repeat_interval))
        else $error("one sensor not base");
    chk_scale_fixed: assert property (@(posedge clk) disable iff (rst)
        sw_end && slider_md && scale == 2'b11 && steps_q == 3'h2 |=> repeat_ms_q == 8'h8c)
        else $error("scale 11 two sensors not 140");
    chk_recal_set: assert property (@(posedge clk) disable iff (rst)
        wr_recal && reg_req.wdata[0] |=> recal_q[0]) else $error("recal not set");
    chk_recal_hold: assert property (@(posedge clk) disable iff (rst)
        recal_q[1] && !(cal_res.done && cal_res.chan == 3'h1) |=> recal_q[1])
        else $error("recal dropped early");
    chk_base_load: assert property (@(posedge clk) disable iff (rst)
        cal_res.done |=> base_q[$past(cal_res.chan)] == $past(cal_res.value))
        else $error("base not updated");
    chk_button_mode: assert property (@(posedge clk) disable iff (rst)
        !slider_md |=> left_q == 3'h0) else $error("extras in button mode");
    chk_extra_total: assert property (@(posedge clk) disable iff (rst)
        sent_q <= {1'b0, lim_q}) else $error("more extras than the limit");
    chk_irq_single: assert property (@(posedge clk) disable iff (rst)
        extra_irq_q |=> !extra_irq_q) else $error("extra irq longer than one cycle");
    chk_cfg_write: assert property (@(posedge clk) disable iff (rst)
        wr_cfg |=> cfg_q == $past(reg_req.wdata)) else $error("config write lost");
    chk_rst_values: assert property (@(posedge clk)
        $past(rst) |-> repeat_ms_q == 8'h23 && recal_q == 8'h00 && !extra_irq_q)
        else $error("bad reset values");
    chk_mid_slide: assert property (@(posedge clk) disable iff (rst)
        slide_end && acc_en && 12'(t_ms_q) * 12'h2 >= 12'(win_ms(win_sel))
        && 12'(t_ms_q) * 12'h4 < 12'(win_ms(win_sel)) * 12'h3
        |=> left_q == $past(max_int) / 3'h2) else $error("mid slide not half");
    chk_late_slide: assert property (@(posedge clk) disable iff (rst)
        slide_end && acc_en && 12'(t_ms_q) * 12'h4 >= 12'(win_ms(win_sel)) * 12'h3
        && t_ms_q <= win_ms(win_sel)
        |=> left_q == ($past(max_int) >= 3'h4 ? 3'h1 : 3'h0))
        else $error("late slide count wrong");
    chk_speed_four: assert property (@(posedge clk) disable iff (rst)
        sw_end && slider_md && steps_q == 3'h4
        |=> repeat_ms_q == ($past(scale) == 2'b11 ? 8'h46 : 8'h23))
        else $error("four sensors wrong interval");
    chk_speed_three: assert property (@(posedge clk) disable iff (rst)
        sw_end && slider_md && steps_q == 3'h3
        |=> repeat_ms_q == ($past(scale) == 2'b11 ? 8'h69 :
                            $past(scale) == 2'b10 ? 8'h46 : 8'h23))
        else $error("three sensors wrong interval");
    chk_speed_two: assert property (@(posedge clk) disable iff (rst)
        sw_end && slider_md && steps_q == 3'h2
        |=> repeat_ms_q == ($past(scale) == 2'b11 ? 8'h8c :
                            $past(scale) == 2'b10 ? 8'h69 :
                            $past(scale) == 2'b01 ? 8'h46 : 8'h23))
        else $error("two sensors wrong interval");
    chk_button_repeat: assert property (@(posedge clk) disable iff (rst)
        sw_end && !slider_md |=> repeat_ms_q == $past(slider_base_repeat_interval))
        else $error("button mode not base interval");
    chk_steps_clear: assert property (@(posedge clk) disable iff (rst)
        sw_end |=> steps_q == {2'b00, $past(sensor_step && slider_md)})
        else $error("speed window not restarted");
    chk_repeat_hold: assert property (@(posedge clk) disable iff (rst)
        !sw_end |=> $stable(repeat_ms_q)) else $error("interval moved mid window");
    chk_group_set: assert property (@(posedge clk) disable iff (rst)
        wr_recal && reg_req.wdata[7] |=> recal_q[7]) else $error("group recal not set");
    chk_recal_clear: assert property (@(posedge clk) disable iff (rst)
        cal_res.done && !(wr_recal && reg_req.wdata[cal_res.chan])
        |=> !recal_q[$past(cal_res.chan)]) else $error("recal bit not cleared");
    chk_zero_write: assert property (@(posedge clk) disable iff (rst)
        wr_recal && !reg_req.wdata[0] && recal_q[0]
        && !(cal_res.done && cal_res.chan == 3'h0)
        |=> recal_q[0]) else $error("zero write aborted recal");
    chk_base_hold: assert property (@(posedge clk) disable iff (rst)
        !cal_res.done |=> $stable(base_q)) else $error("base moved without recal");
endmodule : sarc_top
